// ==== cpmr_regs.sv ====
// Programmer-visible register set with AHB-Lite access
//
// Behaviour
// - Eight data and eight address registers, 32 bits each, plus a 32-bit PC.
// - Data regs take byte, word, long and paired 64-bit quad writes.
// - Address regs and stack pointers accept word and long writes as bases.
// - Any of the sixteen registers can be selected as index value.
// - A 16-bit status word holds a three-bit interrupt priority mask.
// - The status word holds extend, negative, zero, overflow and carry flags.
// - Two trace bits, supervisor bit, master bit; master selects supervisor stack.
// - Full trace set: trap after every retired instruction.
// - Flow trace set: trap only after change-of-flow instructions.
// - A 32-bit vector base register locates the exception table.
// - Three space code outputs encode user/supervisor and program/data each cycle.
// - Source and destination 3-bit alternate space registers set alternate codes.
// - A 32-bit cache control register gives control and status access.
// - A 32-bit cache address register holds the operation target address.
// - Separate 32-bit interrupt and master stack pointers besides user stack.
`timescale 1ns/1ps
module cpmr_regs
  import cpmr_pkg::*;
#(
  parameter int NREG = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire cpmr_cyc_type     coreCycle,
  input  wire cpmr_retire_type  coreRetire,
  output logic [2:0]            space_code_outputs,
  output logic                  traceTrap,
  output logic [31:0]           indexValue,
  output logic [31:0]           activeStack,
  output logic [31:0]           vectorBase,
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] data_regs [NREG];
  logic [31:0] address_regs_nonstack [NREG-1];
  logic [31:0] pcReg, uspReg, ispReg, mspReg, vbaseReg, icache_control_reg,
               icache_address_reg, quadHiReg;
  logic [15:0] processor_status_word;
  logic [2:0]  source_alt_space_reg, dest_alt_space_reg;
  logic [1:0]  irqStatReg, irqMaskReg;
  logic [3:0]  xSelReg;
  logic        xLongReg;

  // Address phase capture
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic [2:0]  wrSize_reg;
  logic [1:0]  wrLane_reg;
  logic [7:0]  rdAddr_next;

  wire         addrPhase = hsel & hready & htrans[1];
  wire         supState  = processor_status_word[PSW_S];
  wire [7:0]   wa        = {wrAddr_reg[7:2], 2'b00};
  wire         isLong    = (wrSize_reg == 3'h2);
  wire         isWord    = (wrSize_reg == 3'h1);
  wire         isByte    = (wrSize_reg == 3'h0);

  // Merge sub-word writes into the old value; bytes/words sit on their lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [2:0] sz, input logic [1:0] ln);
    logic [31:0] m;
    m = 32'hffffffff;
    if (sz == 3'h0)
      m = 32'h000000ff << {ln, 3'h0};
    else if (sz == 3'h1)
      m = 32'h0000ffff << {ln[1], 4'h0};
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [31:0] mergedW = merge(32'h0, hwdata, wrSize_reg, wrLane_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  wire wrEn      = wrPend_reg;
  wire wrDataBk  = wrEn & (wa[7:5] == 3'h0);
  wire wrAddrBk  = wrEn & (wa[7:5] == 3'h1) & ~isByte;
  wire wrSp7     = wrAddrBk & (wa[4:2] == 3'h7);
  wire wrPsw     = wrEn & (wa == OFF_PSW);
  wire wrPswHi   = wrPsw & supState & (isLong | isWord | wrLane_reg[0]);
  wire wrSupOk   = wrEn & supState;
  wire supTarget = wrEn & ((wa == OFF_ISP) | (wa == OFF_MSP) | (wa == OFF_VBASE) |
                   (wa == OFF_SRCSP) | (wa == OFF_DSTSP) | (wa == OFF_ICCTL) |
                   (wa == OFF_ICADR));
  wire denied    = (supTarget | (wrPsw & (isLong | isWord | wrLane_reg[0]))) & ~supState;
  wire wrQuad    = wrEn & (wa == OFF_QUAD);

  // Active stack pointer: user, or interrupt/master by the master bit
  wire [1:0] spSel = {supState, processor_status_word[PSW_M]};
  assign activeStack = !supState ? uspReg :
                       (processor_status_word[PSW_M] ? mspReg : ispReg);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      wrSize_reg <= 3'h0;
      wrLane_reg <= 2'h0;
    end else begin
      wrPend_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr[7:0];
        wrSize_reg <= hsize;
        wrLane_reg <= haddr[1:0];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rdAddr_next = {haddr[7:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Register file writes
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gData
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
          data_regs[g] <= 32'h0;
        else if (wrDataBk && wa[4:2] == 3'(g))
          data_regs[g] <= merge(data_regs[g], hwdata, wrSize_reg, wrLane_reg);
        else if (wrQuad && xSelReg[2:0] == 3'(g))
          data_regs[g] <= hwdata;
      end
    end
    for (g = 0; g < NREG - 1; g++) begin : gAddr
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
          address_regs_nonstack[g] <= 32'h0;
        else if (wrAddrBk && wa[4:2] == 3'(g))
          address_regs_nonstack[g] <= isWord ? {{16{mergedW[31]}}, 16'h0} |
                                      32'(hwdata >> {wrLane_reg[1], 4'h0}) & 32'h0000ffff
                                      | {{16{hwdata[{wrLane_reg[1], 4'hf}]}}, 16'h0}
                                      : hwdata;
      end
    end
  endgenerate

  // Word writes to address regs sign-extend the written half
  function automatic logic [31:0] sext16(input logic [31:0] d, input logic hi);
    logic [15:0] h;
    h = hi ? d[31:16] : d[15:0];
    sext16 = {{16{h[15]}}, h};
  endfunction
  wire [31:0] spData = isWord ? sext16(hwdata, wrLane_reg[1]) : hwdata;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pcReg    <= 32'h0;
      uspReg   <= 32'h0;
      ispReg   <= 32'h0;
      mspReg   <= 32'h0;
      vbaseReg <= 32'h0;
    end else begin
      if (wrEn && wa == OFF_PC)
        pcReg <= hwdata;
      if ((wrEn && wa == OFF_USP && !isByte) || (wrSp7 && spSel[1] == 1'b0))
        uspReg <= spData;
      if (wrSupOk && !isByte && (wa == OFF_ISP || (wrSp7 && spSel == 2'b10)))
        ispReg <= spData;
      if (wrSupOk && !isByte && (wa == OFF_MSP || (wrSp7 && spSel == 2'b11)))
        mspReg <= spData;
      if (wrSupOk && wa == OFF_VBASE)
        vbaseReg <= merge(vbaseReg, hwdata, wrSize_reg, wrLane_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      processor_status_word <= PSW_RST;
      source_alt_space_reg  <= 3'h0;
      dest_alt_space_reg    <= 3'h0;
      icache_control_reg    <= 32'h0;
      icache_address_reg    <= 32'h0;
      quadHiReg             <= 32'h0;
      xSelReg               <= 4'h0;
      xLongReg              <= 1'b1;
    end else begin
      if (wrPsw && (isLong || isWord))
        processor_status_word <= (wrPswHi ? hwdata[15:0]
                                 : {processor_status_word[15:8], hwdata[7:0]})
                                 & PSW_MASK;
      else if (wrPsw && isByte && !wrLane_reg[0] && !wrLane_reg[1])
        processor_status_word[7:0] <= hwdata[7:0] & PSW_MASK[7:0];
      else if (wrPswHi && isByte)
        processor_status_word[15:8] <= hwdata[15:8] & PSW_MASK[15:8];
      if (wrSupOk && wa == OFF_SRCSP)
        source_alt_space_reg <= hwdata[2:0];
      if (wrSupOk && wa == OFF_DSTSP)
        dest_alt_space_reg <= hwdata[2:0];
      if (wrSupOk && wa == OFF_ICCTL)
        icache_control_reg <= hwdata;
      if (wrSupOk && wa == OFF_ICADR)
        icache_address_reg <= hwdata;
      if (wrQuad)
        quadHiReg <= hwdata;
      if (wrEn && wa == OFF_XCTL) begin
        xSelReg  <= hwdata[3:0];
        xLongReg <= hwdata[4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index selection: word index is sign-extended low half
  wire [31:0] xRaw = xSelReg[3] ? (xSelReg[2:0] == 3'h7 ? activeStack
                                   : address_regs_nonstack[xSelReg[2:0]])
                                : data_regs[xSelReg[2:0]];
  wire [31:0] xVal = xLongReg ? xRaw : {{16{xRaw[15]}}, xRaw[15:0]};

  // Space code: alternate registers override the state-derived code
  wire [2:0] spcState = supState ? (coreCycle.prog ? SPC_SPROG : SPC_SDATA)
                              : (coreCycle.prog ? SPC_UPROG : SPC_UDATA);
  wire [2:0] spcNext  = !coreCycle.valid ? 3'h0 :
                        (coreCycle.altSrc ? source_alt_space_reg :
                         coreCycle.altDst ? dest_alt_space_reg : spcState);

  // Trace: full trace on every retirement, flow trace on flow changes only
  wire traceNext = coreRetire.done & (processor_status_word[PSW_FULLTR] |
                   (processor_status_word[PSW_FLOWTR] & coreRetire.flow));

  wire [1:0] irqEvt = {denied, traceNext};
  wire       wrIrqSt = wrEn & (wa == OFF_IRQST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      space_code_outputs <= 3'h0;
      traceTrap          <= 1'b0;
      indexValue         <= 32'h0;
      irqStatReg         <= 2'h0;
      irqMaskReg         <= 2'h0;
    end else begin
      space_code_outputs <= spcNext;
      traceTrap          <= traceNext;
      indexValue         <= xVal;
      irqStatReg         <= (irqStatReg & ~(wrIrqSt ? hwdata[1:0] : 2'h0)) | irqEvt;
      if (wrEn && wa == OFF_IRQMSK)
        irqMaskReg <= hwdata[1:0];
    end
  end

  assign irq        = |(irqStatReg & irqMaskReg);
  assign vectorBase = vbaseReg;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, registered in the data phase
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (rdAddr_next[7:5] == 3'h0)
      rdMux = data_regs[rdAddr_next[4:2]];
    else if (rdAddr_next[7:5] == 3'h1)
      rdMux = (rdAddr_next[4:2] == 3'h7) ? activeStack
                                         : address_regs_nonstack[rdAddr_next[4:2]];
    else begin
      unique case (rdAddr_next)
        OFF_PC:     rdMux = pcReg;
        OFF_USP:    rdMux = uspReg;
        OFF_ISP:    rdMux = ispReg;
        OFF_MSP:    rdMux = mspReg;
        OFF_PSW:    rdMux = {16'h0, processor_status_word};
        OFF_VBASE:  rdMux = vbaseReg;
        OFF_SRCSP:  rdMux = {29'h0, source_alt_space_reg};
        OFF_DSTSP:  rdMux = {29'h0, dest_alt_space_reg};
        OFF_ICCTL:  rdMux = icache_control_reg;
        OFF_ICADR:  rdMux = icache_address_reg;
        OFF_IRQST:  rdMux = {30'h0, irqStatReg};
        OFF_IRQMSK: rdMux = {30'h0, irqMaskReg};
        OFF_XCTL:   rdMux = {27'h0, xLongReg, xSelReg};
        OFF_XVAL:   rdMux = xVal;
        OFF_QUAD:   rdMux = quadHiReg;
        default:    rdMux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hrdata <= 32'h0;
    else if (addrPhase && !hwrite)
      hrdata <= rdMux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trace_full;
    @(posedge clk) disable iff (!rst_b)
      (coreRetire.done && processor_status_word[PSW_FULLTR]) |=> traceTrap;
  endproperty
  a_trace_full: assert property (p_trace_full) else $error("full trace missed");

  property p_trace_flow;
    @(posedge clk) disable iff (!rst_b)
      (coreRetire.done && !processor_status_word[PSW_FULLTR] && !coreRetire.flow) |=> !traceTrap;
  endproperty
  a_trace_flow: assert property (p_trace_flow) else $error("flow trace spurious");

  property p_user_space;
    @(posedge clk) disable iff (!rst_b)
      (coreCycle.valid && !supState && !coreCycle.altSrc && !coreCycle.altDst)
      |=> !space_code_outputs[2];
  endproperty
  a_user_space: assert property (p_user_space) else $error("user cycle shows supervisor");

  property p_alt_src;
    @(posedge clk) disable iff (!rst_b)
      (coreCycle.valid && coreCycle.altSrc) |=> space_code_outputs == $past(source_alt_space_reg);
  endproperty
  a_alt_src: assert property (p_alt_src) else $error("alternate source code wrong");

  property p_vbase_guard;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && wa == OFF_VBASE && !supState) |=> $stable(vbaseReg);
  endproperty
  a_vbase_guard: assert property (p_vbase_guard) else $error("user wrote vector base");

  property p_deny_flag;
    @(posedge clk) disable iff (!rst_b)
      denied |=> irqStatReg[IRQ_DENY];
  endproperty
  a_deny_flag: assert property (p_deny_flag) else $error("denied write not flagged");

  property p_stack_sel;
    @(posedge clk) disable iff (!rst_b)
      (supState && processor_status_word[PSW_M]) |-> activeStack == mspReg;
  endproperty
  a_stack_sel: assert property (p_stack_sel) else $error("master stack not active");

  property p_index;
    @(posedge clk) disable iff (!rst_b)
      (xLongReg && !xSelReg[3]) ##1 $stable(xSelReg) |-> indexValue == $past(data_regs[xSelReg[2:0]]);
  endproperty
  a_index: assert property (p_index) else $error("index value wrong");

  property p_space_idle;
    @(posedge clk) disable iff (!rst_b)
      !coreCycle.valid |=> space_code_outputs == 3'h0;
  endproperty
  a_space_idle: assert property (p_space_idle) else $error("space code without cycle");

  property p_sup_space;
    @(posedge clk) disable iff (!rst_b)
      (coreCycle.valid && supState && !coreCycle.altSrc && !coreCycle.altDst)
      |=> space_code_outputs[2];
  endproperty
  a_sup_space: assert property (p_sup_space) else $error("supervisor cycle shows user");

  property p_alt_dst;
    @(posedge clk) disable iff (!rst_b)
      (coreCycle.valid && !coreCycle.altSrc && coreCycle.altDst)
      |=> space_code_outputs == $past(dest_alt_space_reg);
  endproperty
  a_alt_dst: assert property (p_alt_dst) else $error("alternate destination code wrong");

  // User state may touch the flags but never the control byte
  property p_psw_guard;
    @(posedge clk) disable iff (!rst_b)
      (wrPsw && !supState) |=> $stable(processor_status_word[15:8]);
  endproperty
  a_psw_guard: assert property (p_psw_guard) else $error("user wrote status high byte");

endmodule

// ==== cpmr_pkg.sv ====
// Package: constants and types for the programmer register set
package cpmr_pkg;

  localparam int DATA_W = 32;

  // Register byte offsets on the bus
  localparam logic [7:0] OFF_DATA0  = 8'h00; // data regs 0x00..0x1c
  localparam logic [7:0] OFF_ADDR0  = 8'h20; // address regs 0x20..0x3c
  localparam logic [7:0] OFF_PC     = 8'h40;
  localparam logic [7:0] OFF_USP    = 8'h44;
  localparam logic [7:0] OFF_ISP    = 8'h48;
  localparam logic [7:0] OFF_MSP    = 8'h4c;
  localparam logic [7:0] OFF_PSW    = 8'h50;
  localparam logic [7:0] OFF_VBASE  = 8'h54;
  localparam logic [7:0] OFF_SRCSP  = 8'h58;
  localparam logic [7:0] OFF_DSTSP  = 8'h5c;
  localparam logic [7:0] OFF_ICCTL  = 8'h60;
  localparam logic [7:0] OFF_ICADR  = 8'h64;
  localparam logic [7:0] OFF_IRQST  = 8'h68;
  localparam logic [7:0] OFF_IRQMSK = 8'h6c;
  localparam logic [7:0] OFF_XCTL   = 8'h70; // index select / long index size
  localparam logic [7:0] OFF_XVAL   = 8'h74; // selected index value, read only
  localparam logic [7:0] OFF_QUAD   = 8'h78; // high word of data pair

  // Status word fields
  localparam int PSW_C   = 0;
  localparam int PSW_V   = 1;
  localparam int PSW_Z   = 2;
  localparam int PSW_N   = 3;
  localparam int PSW_X   = 4;
  localparam int PSW_IPL = 8;  // three bits 10:8
  localparam int PSW_M   = 12;
  localparam int PSW_S   = 13;
  localparam int PSW_FULLTR = 14; // full trace
  localparam int PSW_FLOWTR = 15; // flow trace
  localparam logic [15:0] PSW_RST  = 16'h2700;
  localparam logic [15:0] PSW_MASK = 16'hf71f;

  // Interrupt status bits
  localparam int IRQ_TRACE = 0;
  localparam int IRQ_DENY  = 1;

  // Space codes
  localparam logic [2:0] SPC_UDATA = 3'h1;
  localparam logic [2:0] SPC_UPROG = 3'h2;
  localparam logic [2:0] SPC_SDATA = 3'h5;
  localparam logic [2:0] SPC_SPROG = 3'h6;

  typedef struct packed {
    logic       valid;  // one bus cycle in progress
    logic       prog;   // program fetch
    logic       altSrc; // alternate space, source
    logic       altDst; // alternate space, destination
  } cpmr_cyc_type;

  typedef struct packed {
    logic done;   // instruction retired
    logic flow;   // it changed program flow
  } cpmr_retire_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } cpmr_bus_type;

endpackage

// ==== cpmr_mem_model.sv ====
// Memory-side model that decodes the space code outputs
`timescale 1ns/1ps
module cpmr_mem_model (
  input  wire logic [2:0] spaceCode,
  input  wire logic       guardedArea,
  output logic            superAccess,
  output logic            progAccess,
  output logic            refused
);
  logic anyCycle;

  assign anyCycle    = spaceCode != 3'h0;
  assign superAccess = anyCycle & spaceCode[2];
  assign progAccess  = anyCycle & spaceCode[1];
  // User cycles into a guarded area are refused, never served
  assign refused     = anyCycle & ~spaceCode[2] & guardedArea;
endmodule

// ==== testbench.sv ====
// Self-checking bench for the programmer register set
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import cpmr_pkg::*;

  logic            clk;
  logic            rst_b;
  logic            hsel;
  logic [31:0]     haddr;
  logic [1:0]      htrans;
  logic            hwrite;
  logic [31:0]     hwdata;
  logic            hready;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic            hresp;
  cpmr_cyc_type    coreCycle;
  cpmr_retire_type coreRetire;
  logic [2:0]      spaceCodes;
  logic            traceTrap;
  logic [31:0]     indexValue;
  logic [31:0]     activeStack;
  logic [31:0]     vectorBase;
  logic            irq;
  logic            mSuper;
  logic            mProg;
  logic            mRefused;
  int              error_cnt;
  int              comparisons;
  logic [31:0]     junk;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  cpmr_regs uut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .coreCycle(coreCycle), .coreRetire(coreRetire),
    .space_code_outputs(spaceCodes), .traceTrap(traceTrap),
    .indexValue(indexValue), .activeStack(activeStack),
    .vectorBase(vectorBase), .irq(irq)
  );

  cpmr_mem_model partner (
    .spaceCode(spaceCodes), .guardedArea(1'b1), .superAccess(mSuper),
    .progAccess(mProg), .refused(mRefused)
  );

  always #20 clk = ~clk;

  ////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      error_cnt++;
      $display("ERROR t=%0t bus ready never came", $time);
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e);
  endtask

  // Space code is registered one cycle after the core cycle
  task automatic spc(input logic [3:0] c, input logic [2:0] e);
    @(posedge clk);
    coreCycle <= c;
    @(posedge clk);
    #1;
    `CHK(spaceCodes, e);
    `CHK(mSuper, e[2]);
    `CHK(mProg, e[1]);
    `CHK(mRefused, (e != 3'h0) & ~e[2]);
  endtask

  task automatic trc(input logic flow, input logic e);
    @(posedge clk);
    coreRetire <= {1'b1, flow};
    @(posedge clk);
    coreRetire <= 2'b00;
    #1;
    `CHK(traceTrap, e);
    @(posedge clk);
    #1;
    `CHK(traceTrap, 1'b0);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR t=%0t run timed out", $time);
    end_sim();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    coreCycle = 4'h0;
    coreRetire = 2'b00;
    error_cnt = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rc(OFF_PSW, 32'h2700);
    rc(OFF_VBASE, 32'h0);
    `CHK(irq, 1'b0);
    for (int i = 0; i < 16; i++) wr(8'(i * 4), 32'h1000_0000 | i);
    for (int i = 0; i < 16; i++) begin
      rc(8'(i * 4), 32'h1000_0000 | i);
      wr(OFF_XCTL, 32'h10 | i);
      rc(OFF_XVAL, 32'h1000_0000 | i);
      `CHK(indexValue, 32'h1000_0000 | i);
    end
    rc(OFF_ISP, 32'h1000_000f);
    wr(OFF_XCTL, 32'h12);
    wr(OFF_QUAD, 32'hdead_0000);
    rc(OFF_DATA0 + 8'h08, 32'hdead_0000);
    rc(OFF_QUAD, 32'hdead_0000);
    // Word-size index takes the sign-extended low half
    wr(OFF_DATA0 + 8'h0c, 32'h1234_8001);
    wr(OFF_XCTL, 32'h03);
    rc(OFF_XVAL, 32'hffff_8001);
    wr(OFF_PC, 32'h0000_1234);
    rc(OFF_PC, 32'h0000_1234);
    wr(OFF_USP, 32'haaaa_0000);
    rc(OFF_USP, 32'haaaa_0000);
    wr(OFF_MSP, 32'hbbbb_0000);
    rc(OFF_MSP, 32'hbbbb_0000);
    wr(OFF_PSW, 32'h3700);
    rc(OFF_PSW, 32'h3700);
    `CHK(activeStack, 32'hbbbb_0000);
    wr(OFF_PSW, 32'hffff);
    rc(OFF_PSW, 32'hf71f);
    wr(OFF_PSW, 32'h2700);
    rc(OFF_PSW, 32'h2700);
    `CHK(activeStack, 32'h1000_000f);
    wr(OFF_VBASE, 32'h0000_4000);
    rc(OFF_VBASE, 32'h0000_4000);
    `CHK(vectorBase, 32'h0000_4000);
    wr(OFF_ICCTL, 32'h0000_0009);
    rc(OFF_ICCTL, 32'h0000_0009);
    wr(OFF_ICADR, 32'h0012_3450);
    rc(OFF_ICADR, 32'h0012_3450);
    wr(OFF_SRCSP, 32'hffff_ffff);
    rc(OFF_SRCSP, 32'h7);
    wr(OFF_DSTSP, 32'hffff_ffff);
    rc(OFF_DSTSP, 32'h7);
    wr(OFF_SRCSP, {29'h0, SPC_UPROG});
    wr(OFF_DSTSP, {29'h0, SPC_UDATA});
    wr(OFF_PSW, 32'h6700);
    trc(1'b0, 1'b1);
    wr(OFF_PSW, 32'ha700);
    trc(1'b0, 1'b0);
    trc(1'b1, 1'b1);
    wr(OFF_PSW, 32'h2700);
    trc(1'b1, 1'b0);
    rc(OFF_IRQST, 32'h1);
    wr(OFF_IRQST, 32'h1);
    rc(OFF_IRQST, 32'h0);
    spc(4'b1100, SPC_SPROG);
    spc(4'b1000, SPC_SDATA);
    spc(4'b1010, SPC_UPROG);
    spc(4'b1001, SPC_UDATA);
    spc(4'b0000, 3'h0);
    rc(8'h7c, 32'h0);
    `CHK(hresp, 1'b0);
    // Dropping to user state is one-way; these checks come last
    wr(OFF_PSW, 32'h0000);
    rc(OFF_PSW, 32'h0000);
    `CHK(activeStack, 32'haaaa_0000);
    spc(4'b1100, SPC_UPROG);
    spc(4'b1000, SPC_UDATA);
    spc(4'b0000, 3'h0);
    wr(OFF_VBASE, 32'h0000_0009);
    rc(OFF_VBASE, 32'h0000_4000);
    wr(OFF_ISP, 32'h0000_0005);
    rc(OFF_ISP, 32'h1000_000f);
    wr(OFF_PSW, 32'h271f);
    rc(OFF_PSW, 32'h001f);
    `CHK(irq, 1'b0);
    rc(OFF_IRQST, 32'h2);
    wr(OFF_IRQMSK, 32'h2);
    rc(OFF_IRQMSK, 32'h2);
    `CHK(irq, 1'b1);
    wr(OFF_IRQST, 32'h2);
    rc(OFF_IRQST, 32'h0);
    `CHK(irq, 1'b0);
    end_sim();
  end
endmodule
